//--- tx_signaling_insertion_select.v
// Purpose: Transmit signaling insertion selector of a T1/E1 framer port.
// Assumes: clk_sys at 200 MHz; backplane clock, serial data, signaling
//          and frame sync are sampled on clk_sys through two flip-flops.
// Notes: Avalon-MM slave answers one cycle after a request is seen.
//
// Summary of operation
// - E1 CAS: enable1 bit0 takes upper align nibble from first signaling register.
// - E1 CAS: enable1 bits 1-7 enable register signaling for channels 1-7.
// - E1 CAS: enable2 bits 0-7 enable register signaling for channels 8-15.
// - E1 CAS: enable3 bit0 takes lower align bits from first signaling register.
// - E1 CAS: enable3 bits 1-7 enable register signaling for channels 16-22.
// - E1 CAS: enable4 bits 0-7 enable register signaling for channels 23-30.
// - Enable bit 1 sources from signaling registers; 0 does not.
// - T1 uses only enable registers 1-3; enable4 has no effect.
// - T1: enable1 bits 0-7 select channels 1-8.
// - T1: enable2 bits 0-7 select channels 9-16.
// - T1: enable3 bits 0-7 select channels 17-24.
// - All enable bits reset to zero.
// - Hardware mode buffers signaling input and merges it into serial data.
// - Hardware signaling goes only into channels picked by the hardware select.
// - Insertion works with the elastic store on or off.
// - First signaling register holds align nibble high, alarm bits low; regs at 50h-5Fh.
// - Register signaling enters only when the mode's global enable is set.
`timescale 1ns/1ps
`include "sig_insert_defines.vh"
module tx_signaling_insertion_select (
    input wire clk_sys,
    input wire rst,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire tx_backplane_clock,
    input wire tx_frame_sync,
    input wire tx_serial_data_in,
    input wire tx_signaling_serial_in,
    output reg tx_serial_data_out,
    output reg tx_bit_valid
);

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    reg [7:0] sig_insert_enable_1_reg;
    reg [7:0] sig_insert_enable_2_reg;
    reg [7:0] sig_insert_enable_3_reg;
    reg [7:0] sig_insert_enable_4_reg;
    reg [7:0] ctrl_reg;
    reg [31:0] hw_select_reg;
    reg [7:0] tx_signaling_regs [0:15];
    reg [3:0] status_reg;
    reg ack_reg;
    integer i;

    wire access = (avs_read | avs_write) & ~ack_reg;
    // A write lands at the edge at which the master sees waitrequest low,
    // one cycle after it was taken, so the store and the handshake agree
    // on a single edge.
    wire wr_en = avs_write & ack_reg & avs_byteenable[0];
    wire [7:0] wdata = avs_writedata[7:0];
    wire in_sig_range = (avs_address >= `OFS_TX_SIG_BASE) && (avs_address <= `OFS_TX_SIG_LAST);
    wire [3:0] sig_index = avs_address[3:0];

    // Every register is one byte wide; the upper byte lanes read as zero.
    function [31:0] byte_word;
        input [7:0] value;
        begin
            byte_word = {24'h000000, value};
        end
    endfunction

    // ----------------------------------------------------------------
    // Avalon-MM slave: one wait cycle, answer on the second edge.
    // ----------------------------------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ack_reg <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= `UNMAPPED_READ;
        end else begin
            ack_reg <= access;
            avs_waitrequest <= ~access;
            if (access && avs_read) begin
                avs_readdata <= `UNMAPPED_READ;
                if (in_sig_range)
                    avs_readdata <= byte_word(tx_signaling_regs[sig_index]);
                else begin
                    case (avs_address)
                        `OFS_SIG_INSERT_ENABLE_1: avs_readdata <= byte_word(sig_insert_enable_1_reg);
                        `OFS_SIG_INSERT_ENABLE_2: avs_readdata <= byte_word(sig_insert_enable_2_reg);
                        `OFS_SIG_INSERT_ENABLE_3: avs_readdata <= byte_word(sig_insert_enable_3_reg);
                        `OFS_SIG_INSERT_ENABLE_4: avs_readdata <= byte_word(sig_insert_enable_4_reg);
                        `OFS_CTRL: avs_readdata <= byte_word(ctrl_reg);
                        `OFS_HW_SELECT_1: avs_readdata <= byte_word(hw_select_reg[7:0]);
                        `OFS_HW_SELECT_2: avs_readdata <= byte_word(hw_select_reg[15:8]);
                        `OFS_HW_SELECT_3: avs_readdata <= byte_word(hw_select_reg[23:16]);
                        `OFS_HW_SELECT_4: avs_readdata <= byte_word(hw_select_reg[31:24]);
                        `OFS_STATUS: avs_readdata <= {28'h0000000, status_reg};
                        default: avs_readdata <= `UNMAPPED_READ;
                    endcase
                end
            end
        end
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sig_insert_enable_1_reg <= `REG_RESET;
            sig_insert_enable_2_reg <= `REG_RESET;
            sig_insert_enable_3_reg <= `REG_RESET;
            sig_insert_enable_4_reg <= `REG_RESET;
            ctrl_reg <= `REG_RESET;
            hw_select_reg <= 32'h0000_0000;
            for (i = 0; i < 16; i = i + 1)
                tx_signaling_regs[i] <= `REG_RESET;
        end else if (wr_en) begin
            if (in_sig_range)
                tx_signaling_regs[sig_index] <= wdata;
            else begin
                case (avs_address)
                    `OFS_SIG_INSERT_ENABLE_1: sig_insert_enable_1_reg <= wdata;
                    `OFS_SIG_INSERT_ENABLE_2: sig_insert_enable_2_reg <= wdata;
                    `OFS_SIG_INSERT_ENABLE_3: sig_insert_enable_3_reg <= wdata;
                    `OFS_SIG_INSERT_ENABLE_4: sig_insert_enable_4_reg <= wdata;
                    `OFS_CTRL: ctrl_reg <= {3'h0, wdata[4:0]};
                    `OFS_HW_SELECT_1: hw_select_reg[7:0] <= wdata;
                    `OFS_HW_SELECT_2: hw_select_reg[15:8] <= wdata;
                    `OFS_HW_SELECT_3: hw_select_reg[23:16] <= wdata;
                    `OFS_HW_SELECT_4: hw_select_reg[31:24] <= wdata;
                    default: ;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Backplane inputs
    // ----------------------------------------------------------------
    wire bclk_rise;
    wire fsync_level;
    wire data_level;
    wire sig_level;

    edge_sync u_clk_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in(tx_backplane_clock),
        .level_out(),
        .rise_out(bclk_rise)
    );

    edge_sync u_fsync_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in(tx_frame_sync),
        .level_out(fsync_level),
        .rise_out()
    );

    edge_sync u_data_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in(tx_serial_data_in),
        .level_out(data_level),
        .rise_out()
    );

    edge_sync u_sig_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in(tx_signaling_serial_in),
        .level_out(sig_level),
        .rise_out()
    );

    // ----------------------------------------------------------------
    // Frame position counter and multiframe signaling pointer
    // ----------------------------------------------------------------
    // Bit counter restarts on frame sync; E1 frames have 256 bits, T1 193.
    // The elastic store lies outside; the selector only follows the
    // backplane clock, so it runs the same with the store on or off.
    reg [8:0] bit_cnt_reg;
    reg [3:0] frame_cnt_reg;
    wire e1_mode = ctrl_reg[`CTRL_E1_MODE];
    wire [8:0] frame_len = e1_mode ? `E1_FRAME_BITS : `T1_FRAME_BITS;

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bit_cnt_reg <= 9'h000;
            frame_cnt_reg <= 4'h0;
        end else if (bclk_rise) begin
            if (fsync_level) begin
                // A sync on a wrapped counter opens a frame already counted
                // at the wrap; only an early sync must advance the index.
                bit_cnt_reg <= 9'h001;
                if (bit_cnt_reg != 9'h000)
                    frame_cnt_reg <= frame_cnt_reg + 4'h1;
            end else if (bit_cnt_reg == frame_len - 9'h001) begin
                bit_cnt_reg <= 9'h000;
                frame_cnt_reg <= frame_cnt_reg + 4'h1;
            end else
                bit_cnt_reg <= bit_cnt_reg + 9'h001;
        end
    end

    // ----------------------------------------------------------------
    // Channel decode
    // ----------------------------------------------------------------
    // E1: slot = bit/8, CAS in slot 16. T1: bit 0 is F, the 8th bit of
    // every channel carries robbed-bit signaling.
    wire [4:0] e1_slot = bit_cnt_reg[7:3];
    wire [2:0] e1_bit = bit_cnt_reg[2:0];
    wire [8:0] t1_pos = bit_cnt_reg - 9'h001;
    wire [4:0] t1_chan = t1_pos[7:3];
    wire t1_sig_pos = (bit_cnt_reg != 9'h000) && (t1_pos[2:0] == 3'h7);
    wire e1_sig_pos = (e1_slot == `E1_CAS_SLOT);

    // Map a 32-bit channel enable vector bit out of the four enable bytes.
    function [31:0] chan_enables;
        input e1;
        input [7:0] r1;
        input [7:0] r2;
        input [7:0] r3;
        input [7:0] r4;
        begin
            if (e1) // Bit n is phone channel n (bit 0 unused).
                chan_enables = {1'b0, r4, r3[7:1], r2, r1[7:1], 1'b0};
            else // Bit n-1 is channel n; enable 4 ignored.
                chan_enables = {8'h00, r3, r2, r1};
        end
    endfunction

    // Each signaling byte packs a channel pair: the odd channel in the low
    // nibble, the even one in the high nibble, A bit on the higher index.
    // Both modes and the align byte read the store through this decode.
    function sig_reg_bit;
        input [7:0] byte_val;
        input high_nibble;
        input [1:0] bit_sel;
        begin
            if (high_nibble)
                sig_reg_bit = byte_val[3'h7 - {1'b0, bit_sel}];
            else
                sig_reg_bit = byte_val[3'h3 - {1'b0, bit_sel}];
        end
    endfunction

    wire [31:0] sw_chan = chan_enables(e1_mode, sig_insert_enable_1_reg, sig_insert_enable_2_reg,
        sig_insert_enable_3_reg, sig_insert_enable_4_reg);

    // In E1 CAS the frame 0 CAS slot is the align/alarm byte; in other
    // frames the high nibble serves one channel and the low the other.
    wire [3:0] mf_frame = frame_cnt_reg;
    wire e1_align_frame = (mf_frame == 4'h0);
    wire [4:0] e1_chan = e1_bit[2] ? (mf_frame + 5'd15) : {1'b0, mf_frame};
    // Phone channel n sits in byte (n + 1) / 2 of the store, so the byte
    // follows the channel, not the frame number.
    wire [4:0] e1_chan_inc = e1_chan + 5'h01;
    wire [3:0] e1_sig_index = e1_chan_inc[4:1];
    wire [7:0] first_sig = tx_signaling_regs[0];
    wire [7:0] e1_sig_byte = tx_signaling_regs[e1_sig_index];

    // ----------------------------------------------------------------
    // Per-bit source decision
    // ----------------------------------------------------------------
    // T1 signaling rides the last bit of every channel in every frame, with
    // the nibble bit chosen by the frame index modulo four; a line framer
    // that robs only selected frames must gate this further downstream.
    reg sw_en_bit;
    reg sw_data_bit;
    reg hw_en_bit;
    reg sig_pos;

    always @* begin
        sw_en_bit = 1'b0;
        sw_data_bit = 1'b0;
        hw_en_bit = 1'b0;
        sig_pos = 1'b0;
        if (e1_mode) begin
            sig_pos = e1_sig_pos;
            if (e1_align_frame) begin
                sw_en_bit = e1_bit[2] ? sig_insert_enable_3_reg[0] : sig_insert_enable_1_reg[0];
                sw_data_bit = sig_reg_bit(first_sig, ~e1_bit[2], e1_bit[1:0]);
            end else begin
                sw_en_bit = sw_chan[e1_chan];
                sw_data_bit = sig_reg_bit(e1_sig_byte, ~e1_chan[0], e1_bit[1:0]);
            end
            sw_en_bit = sw_en_bit & ctrl_reg[`CTRL_E1_GLOBAL_EN];
            hw_en_bit = hw_select_reg[e1_slot];
        end else begin
            sig_pos = t1_sig_pos;
            sw_en_bit = sw_chan[t1_chan] & ctrl_reg[`CTRL_T1_GLOBAL_EN];
            sw_data_bit = sig_reg_bit(tx_signaling_regs[t1_chan[4:1]], t1_chan[0], mf_frame[1:0]);
            hw_en_bit = hw_select_reg[t1_chan];
        end
        hw_en_bit = hw_en_bit & ctrl_reg[`CTRL_HW_MODE];
    end

    // ----------------------------------------------------------------
    // Output merge
    // ----------------------------------------------------------------
    wire mux_bit;
    wire [1:0] mux_source;

    // Register signaling outranks the hardware stream when a channel is
    // picked by both, so software can override a faulty backplane source.
    sig_bit_select u_select (
        .sig_position(sig_pos),
        .sw_enable(sw_en_bit),
        .sw_bit(sw_data_bit),
        .hw_enable(hw_en_bit),
        .hw_bit(sig_level),
        .data_bit(data_level),
        .out_bit(mux_bit),
        .source(mux_source)
    );

    // The signaling stream is held one bit alongside the data, which is
    // the buffering the hardware path needs; no deeper store is kept.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_serial_data_out <= 1'b0;
            tx_bit_valid <= 1'b0;
            status_reg <= 4'h0;
        end else begin
            tx_bit_valid <= bclk_rise;
            if (bclk_rise) begin
                tx_serial_data_out <= mux_bit;
                status_reg <= {2'h0, mux_source};
            end
        end
    end

endmodule // tx_signaling_insertion_select

//--- sig_insert_defines.vh
// Purpose: Constants for the transmit signaling insertion selector.
// Assumes: Avalon-MM word addressing, one 8-bit register per word.
// Notes: Register offsets, the 8-bit register reset value and frame bit counts live here.
`ifndef SIG_INSERT_DEFINES_VH
`define SIG_INSERT_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets (word index)
// ----------------------------------------------------------------
`define ADDR_W 8
`define OFS_SIG_INSERT_ENABLE_1 8'h08
`define OFS_SIG_INSERT_ENABLE_2 8'h09
`define OFS_SIG_INSERT_ENABLE_3 8'h0a
`define OFS_SIG_INSERT_ENABLE_4 8'h0b
`define OFS_CTRL 8'h0c
`define OFS_HW_SELECT_1 8'h0d
`define OFS_HW_SELECT_2 8'h0e
`define OFS_HW_SELECT_3 8'h0f
`define OFS_HW_SELECT_4 8'h10
`define OFS_STATUS 8'h11
`define OFS_TX_SIG_BASE 8'h50
`define OFS_TX_SIG_LAST 8'h5f

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define CTRL_E1_MODE 0
`define CTRL_T1_GLOBAL_EN 1
`define CTRL_E1_GLOBAL_EN 2
`define CTRL_HW_MODE 3
`define CTRL_ELASTIC_EN 4
`define REG_RESET 8'h00
`define UNMAPPED_READ 32'h0000_0000

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define T1_FRAME_BITS 9'd193
`define E1_FRAME_BITS 9'd256
`define E1_CAS_SLOT 5'd16

`endif

//--- edge_sync.v
// Purpose: Two-stage synchroniser with a rising edge detector.
// Assumes: Input is asynchronous to clk_sys.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module edge_sync (
    input wire clk_sys,
    input wire rst,
    input wire async_in,
    output wire level_out,
    output wire rise_out
);
    reg meta_reg;
    reg sync_reg;
    reg prev_reg;

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign level_out = sync_reg;
    assign rise_out = sync_reg & ~prev_reg;
endmodule // edge_sync

//--- sig_bit_select.v
// Purpose: Chooses the source of one outgoing serial bit.
// Assumes: Position flags are already decoded by the caller.
// Notes: Pure combinational; priority is register, hardware, pass.
`timescale 1ns/1ps
module sig_bit_select (
    input wire sig_position,
    input wire sw_enable,
    input wire sw_bit,
    input wire hw_enable,
    input wire hw_bit,
    input wire data_bit,
    output reg out_bit,
    output reg [1:0] source
);
    always @* begin
        out_bit = data_bit;
        source = 2'h0;
        if (sig_position && sw_enable) begin
            out_bit = sw_bit;
            source = 2'h1;
        end else if (sig_position && hw_enable) begin
            out_bit = hw_bit;
            source = 2'h2;
        end
    end
endmodule // sig_bit_select

//--- sig_insert_chk.sv
// Purpose: Port-level assertions for the transmit signaling insertion selector.
// Assumes: Only the top module's ports are visible; single clk_sys domain.
// Notes: Link timing windows allow one cycle of slack before and two cycles after the detection delay.
`timescale 1ns/1ps
module sig_insert_chk (
    input wire clk_sys,
    input wire rst,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire tx_backplane_clock,
    input wire tx_frame_sync,
    input wire tx_serial_data_in,
    input wire tx_signaling_serial_in,
    input wire tx_serial_data_out,
    input wire tx_bit_valid
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    wire mapped = (avs_address >= 8'h08 && avs_address <= 8'h11) || (avs_address >= 8'h50 && avs_address <= 8'h5f);

    a_req_answer: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
        else $error("request not answered in one cycle");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_wait_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("answer without a request");
    a_unmapped_read: assert property (avs_read && !avs_waitrequest && !mapped |-> avs_readdata == 32'h0)
        else $error("unmapped read returned data");
    a_upper_zero: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_valid_single: assert property (tx_bit_valid |=> !tx_bit_valid)
        else $error("bit valid longer than one cycle");
    a_edge_to_valid: assert property ($rose(tx_backplane_clock) |-> ##[2:5] tx_bit_valid)
        else $error("backplane edge without output bit");
    a_valid_cause: assert property (tx_bit_valid |-> $past(tx_backplane_clock, 2) && !$past(tx_backplane_clock, 9))
        else $error("bit valid without a backplane edge");
    a_data_on_valid: assert property ($changed(tx_serial_data_out) |-> tx_bit_valid)
        else $error("serial output changed between bits");
endmodule // sig_insert_chk

bind tx_signaling_insertion_select sig_insert_chk chk (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tx_backplane_clock(tx_backplane_clock),
    .tx_frame_sync(tx_frame_sync), .tx_serial_data_in(tx_serial_data_in),
    .tx_signaling_serial_in(tx_signaling_serial_in), .tx_serial_data_out(tx_serial_data_out),
    .tx_bit_valid(tx_bit_valid));

//--- backplane_model.sv
// Purpose: Behavioural TDM backplane sending one frame per request.
// Assumes: 80 ns bit clock, its edges 1 ns after a clk_sys edge.
// Notes: The clock stands still between frames; data changes while it is low.
`timescale 1ns/1ps
module backplane_model (
    output logic link_clk,
    output logic frame_sync,
    output logic ser_data,
    output logic sig_data,
    input wire logic go,
    input wire logic [8:0] frame_bits
);
    int bit_idx = 0;
    int frames = 0;
    logic [31:0] sr = 32'he50692de;

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    initial begin
        link_clk = 1'b0;
        frame_sync = 1'b0;
        ser_data = 1'b0;
        sig_data = 1'b0;
        #7;
        forever begin
            wait (go === 1'b1);
            // Step off the clk_sys edge on which go was raised, so no
            // backplane edge ever falls on a sampling edge.
            #1;
            for (int i = 0; i < frame_bits; i++) begin
                bit_idx = i;
                frame_sync = (i == 0);
                sr = lfsr(sr);
                ser_data = sr[0];
                sig_data = sr[7];
                #40 link_clk = 1'b1;
                #40 link_clk = 1'b0;
            end
            frames++;
            wait (go === 1'b0);
        end
    end
endmodule // backplane_model

//--- tx_signaling_insertion_select_tb_top.sv
// Purpose: Self-checking bench for the transmit signaling insertion selector.
// Assumes: T1 signaling bit is the last bit of each channel; all signaling registers hold ones.
// Notes: With ones in the signaling registers the register source shows as a 1 whatever the frame index.
`timescale 1ns/1ps
module tx_signaling_insertion_select_tb_top;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, bp_clk, bp_sync, bp_data, bp_sig, tx_serial_data_out, tx_bit_valid;
    logic go = 1'b0;
    logic [8:0] fbits = 9'd193;
    int error_cnt = 0;
    int checked = 0;
    logic [7:0] ctrl = 8'h00;
    logic [7:0] q;
    logic [23:0] en = 24'h0;
    logic [7:0] en4 = 8'h00;
    logic [31:0] hw = 32'h0;
    logic [31:0] rnd = 32'he50692de;
    logic mon = 1'b0;

    always #2.5 clk_sys = ~clk_sys;

    tx_signaling_insertion_select dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .tx_backplane_clock(bp_clk), .tx_frame_sync(bp_sync), .tx_serial_data_in(bp_data),
        .tx_signaling_serial_in(bp_sig), .tx_serial_data_out(tx_serial_data_out), .tx_bit_valid(tx_bit_valid));
    backplane_model bp (.link_clk(bp_clk), .frame_sync(bp_sync), .ser_data(bp_data), .sig_data(bp_sig),
        .go(go), .frame_bits(fbits));

    // Expected output bit: register first, then hardware, otherwise the data passes.
    // E1: bit f of {en4, en} serves the upper nibble of frame f, bit f + 16 the lower.
    function automatic logic exp_bit(input int idx, input int fr, input logic d, input logic s);
        int ch;
        logic [31:0] ev;
        ch = idx / 8;
        ev = {en4, en};
        if (ctrl[0]) begin
            if (ch != 16) return d;
            if (ctrl[2] && ev[(idx % 8 < 4) ? fr % 16 : fr % 16 + 16]) return 1'b1;
            if (ctrl[3] && hw[16]) return s;
            return d;
        end
        if (idx == 0 || idx % 8 != 0) return d;
        if (ctrl[1] && en[ch - 1]) return 1'b1;
        if (ctrl[3] && hw[ch - 1]) return s;
        return d;
    endfunction

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t bit got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h0, d};
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            error_cnt++;
            end_sim;
        end
        q = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic frame(input logic [7:0] c, input logic [23:0] e, input logic [7:0] e4, input logic [31:0] h);
        int f0;
        bus(1'b1, 8'h08, e[7:0]);
        bus(1'b1, 8'h09, e[15:8]);
        bus(1'b1, 8'h0a, e[23:16]);
        bus(1'b1, 8'h0b, e4);
        bus(1'b1, 8'h0c, c);
        for (int k = 0; k < 4; k++) bus(1'b1, 8'h0d + 8'(k), h[8 * k +: 8]);
        ctrl = c;
        en = e;
        en4 = e4;
        hw = h;
        fbits <= c[0] ? 9'd256 : 9'd193;
        f0 = bp.frames;
        go <= 1'b1;
        mon = 1'b1;
        while (bp.frames == f0) @(posedge clk_sys);
        go <= 1'b0;
        mon = 1'b0;
        @(posedge clk_sys);
    endtask

    always @(posedge clk_sys) begin
        if (mon && tx_bit_valid === 1'b1)
            chk_bit(tx_serial_data_out, exp_bit(bp.bit_idx, bp.frames, bp_data, bp_sig));
    end

    task end_sim;
        if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #400000;
        error_cnt++;
        end_sim;
    end

    initial begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        for (int a = 8; a < 12; a++) begin
            bus(1'b0, a[7:0], 8'h00);
            chk_reg(q, 8'h00);
        end
        for (int a = 8; a < 12; a++) begin
            rnd = lfsr(rnd);
            bus(1'b1, a[7:0], rnd[7:0]);
            bus(1'b0, a[7:0], 8'h00);
            chk_reg(q, rnd[7:0]);
        end
        avs_byteenable <= 4'h0;
        bus(1'b1, 8'h0b, ~rnd[7:0]);
        avs_byteenable <= 4'hf;
        bus(1'b0, 8'h0b, 8'h00);
        chk_reg(q, rnd[7:0]);
        bus(1'b1, 8'h30, 8'hff);
        bus(1'b0, 8'h30, 8'h00);
        chk_reg(q, 8'h00);
        for (int a = 8'h50; a <= 8'h5f; a++) bus(1'b1, a[7:0], 8'hff);
        bus(1'b0, 8'h5f, 8'h00);
        chk_reg(q, 8'hff);
        rnd = lfsr(rnd);
        frame(8'h05, {rnd[23:17], 1'b1, rnd[15:1], 1'b1}, rnd[31:24], 32'h0);
        frame(8'h00, 24'hffffff, 8'hff, 32'h0);
        frame(8'h02, 24'h808001, 8'hff, 32'h0);
        rnd = lfsr(rnd);
        frame(8'h0a, 24'h808001, 8'h00, rnd);
        rnd = lfsr(rnd);
        frame(8'h1a, {rnd[23:1], 1'b0}, 8'h00, ~rnd);
        frame(8'h01, 24'hffffff, 8'hff, 32'h0);
        for (int k = 0; k < 3; k++) begin
            rnd = lfsr(rnd);
            frame(8'h0d, rnd[23:0], rnd[31:24], ~rnd);
        end
        end_sim;
    end
endmodule // tx_signaling_insertion_select_tb_top
